/* File: verilog/pau_regs.sv */
// Protection attribute registers of the system control coprocessor
`timescale 1ns/1ns
`default_nettype none
`include "pau_defs.svh"
// Function
// - Control bits 31:30 pick clock mode: 00 fast, 01 sync, 11 async.
// - Cachable location: secondary opcode 0 data, 1 instruction register.
// - Cachable registers hold eight bits, one per area, set means cachable.
// - Bufferable register holds one bit per data area, set means buffered.
// - Write buffer treatment combines each area's bufferable and cachable.
// - Permission location: secondary opcode 0 data, 1 instruction.
// - Permission registers hold two bits per area, area n at 2n+1:2n.
// - Codes: 00 none, 01 privileged only, 10 user read, 11 full.
// - Permissions cleared to 00 at reset; unit disabled so nothing accessible.
// - Sixteen region registers, ignored while the unit is disabled.
// - Reset clears only each region's enable bit.
// - Region side from secondary opcode, region number from minor field.
// - Region holds base 31:12, size 5:1, enable bit 0.
// - Control bit 0 enables the protection unit.
module pau_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_cp_valid,
  input  wire logic        i_cp_write,
  input  wire logic [3:0]  i_cp_crn,
  input  wire logic [3:0]  i_cp_crm,
  input  wire logic [2:0]  i_cp_op2,
  input  wire logic [31:0] i_cp_wdata,
  input  wire logic        i_chk_instr,
  input  wire logic [2:0]  i_chk_area,
  input  wire logic        i_chk_user,
  input  wire logic        i_chk_write,
  output logic [31:0]      o_cp_rdata,
  output logic             o_cp_rvalid,
  output logic [1:0]       o_clock_mode,
  output logic             o_prot_enable,
  output logic [7:0]       o_data_cachable,
  output logic [7:0]       o_instr_cachable,
  output logic [7:0]       o_data_bufferable,
  output logic [15:0]      o_data_perm,
  output logic [15:0]      o_instr_perm,
  output logic [15:0]      o_area_write_mode,
  output logic [15:0]      o_region_active,
  output logic             o_chk_allow
);
  pau_pkg::pau_top_st_t st_ff;
  pau_pkg::pau_top_st_t nxt_st;
  pau_rgn_if            rgn ();
  logic                 wr_req;
  logic                 rd_req;
  logic                 side_ok;
  logic                 op2_instr;
  logic [1:0]           chk_perm;

  // Transfer to a given location
  function automatic logic hit(input logic [3:0] crn,
                               input logic [3:0] want);
    hit = (crn == want);
  endfunction

  // Permission code against access kind
  function automatic logic perm_ok(input logic [1:0] ap,
                                   input logic user,
                                   input logic wr);
    unique case (pau_pkg::pau_perm_t'(ap))
      pau_pkg::PAU_AP_NONE: perm_ok = 1'b0;
      pau_pkg::PAU_AP_PRIV: perm_ok = !user;
      pau_pkg::PAU_AP_URD:  perm_ok = !user || !wr;
      pau_pkg::PAU_AP_FULL: perm_ok = 1'b1;
    endcase
  endfunction

  assign wr_req    = i_cp_valid && i_cp_write;
  assign rd_req    = i_cp_valid && !i_cp_write;
  assign side_ok   = (i_cp_op2 == `PAU_OP2_DATA) ||
                     (i_cp_op2 == `PAU_OP2_INSTR);
  assign op2_instr = (i_cp_op2 == `PAU_OP2_INSTR);

  assign rgn.wr    = wr_req && hit(i_cp_crn, `PAU_CRN_REGION) &&
                     side_ok && !i_cp_crm[3];
  assign rgn.side  = op2_instr;
  assign rgn.idx   = i_cp_crm[2:0];
  assign rgn.wdata = i_cp_wdata;

  pau_rgn_store u_store (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .rgn       (rgn)
  );

  assign chk_perm = i_chk_instr ? st_ff.iperm[{i_chk_area, 1'b0} +: 2]
                                : st_ff.dperm[{i_chk_area, 1'b0} +: 2];

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rvalid = rd_req;
    nxt_st.rdata = 32'h0000_0000;
    if (wr_req && side_ok)
    begin
      if (hit(i_cp_crn, `PAU_CRN_CTRL))
      begin
        nxt_st.mode = pau_pkg::pau_clk_mode_t'(
          i_cp_wdata[`PAU_CTRL_MODE_HI:`PAU_CTRL_MODE_LO]);
        nxt_st.prot_en = i_cp_wdata[`PAU_CTRL_PEN];
      end
      if (hit(i_cp_crn, `PAU_CRN_CACHE))
      begin
        if (op2_instr)
          nxt_st.icach = i_cp_wdata[7:0];
        else
          nxt_st.dcach = i_cp_wdata[7:0];
      end
      if (hit(i_cp_crn, `PAU_CRN_BUFF) && !op2_instr)
        nxt_st.dbuf = i_cp_wdata[7:0];
      if (hit(i_cp_crn, `PAU_CRN_PERM))
      begin
        if (op2_instr)
          nxt_st.iperm = i_cp_wdata[15:0];
        else
          nxt_st.dperm = i_cp_wdata[15:0];
      end
    end
    if (rd_req && side_ok)
    begin
      if (hit(i_cp_crn, `PAU_CRN_CTRL))
      begin
        nxt_st.rdata[`PAU_CTRL_MODE_HI:`PAU_CTRL_MODE_LO] = st_ff.mode;
        nxt_st.rdata[`PAU_CTRL_PEN] = st_ff.prot_en;
      end
      if (hit(i_cp_crn, `PAU_CRN_CACHE))
        nxt_st.rdata[7:0] = op2_instr ? st_ff.icach : st_ff.dcach;
      if (hit(i_cp_crn, `PAU_CRN_BUFF) && !op2_instr)
        nxt_st.rdata[7:0] = st_ff.dbuf;
      if (hit(i_cp_crn, `PAU_CRN_PERM))
        nxt_st.rdata[15:0] = op2_instr ? st_ff.iperm : st_ff.dperm;
      if (hit(i_cp_crn, `PAU_CRN_REGION) && !i_cp_crm[3])
        nxt_st.rdata = rgn.rdata;
    end
    for (int n = 0; n < `PAU_AREAS; n++)
      nxt_st.wmode[2*n +: 2] = {st_ff.dcach[n], st_ff.dbuf[n]};
    // Regions and permissions count only while the unit is on
    nxt_st.active = st_ff.prot_en ? (rgn.en & rgn.sz_ok)
                                  : 16'h0000;
    nxt_st.allow = st_ff.prot_en &&
                   perm_ok(chk_perm, i_chk_user, i_chk_write);
    if (!i_reset_n)
    begin
      nxt_st = '0;
      nxt_st.mode = pau_pkg::PAU_MODE_FAST;
    end
  end

  always_ff @(posedge i_sys_clk)
    st_ff <= nxt_st;

  assign o_cp_rdata        = st_ff.rdata;
  assign o_cp_rvalid       = st_ff.rvalid;
  assign o_clock_mode      = st_ff.mode;
  assign o_prot_enable     = st_ff.prot_en;
  assign o_data_cachable   = st_ff.dcach;
  assign o_instr_cachable  = st_ff.icach;
  assign o_data_bufferable = st_ff.dbuf;
  assign o_data_perm       = st_ff.dperm;
  assign o_instr_perm      = st_ff.iperm;
  assign o_area_write_mode = st_ff.wmode;
  assign o_region_active   = st_ff.active;
  assign o_chk_allow       = st_ff.allow;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_mode_decode: assert property (
    wr_req && hit(i_cp_crn, `PAU_CRN_CTRL) && side_ok
    |=> o_clock_mode == $past(i_cp_wdata[31:30]))
    else $error("clock mode not taken from bits 31:30");
  a_enable_bit: assert property (
    wr_req && hit(i_cp_crn, `PAU_CRN_CTRL) && side_ok
    |=> o_prot_enable == $past(i_cp_wdata[0]))
    else $error("protection enable not taken from bit 0");
  a_cache_route: assert property (
    wr_req && hit(i_cp_crn, `PAU_CRN_CACHE) && i_cp_op2 == 3'h0
    |=> o_data_cachable == $past(i_cp_wdata[7:0]) &&
        $stable(o_instr_cachable))
    else $error("data cachable write misrouted");
  a_perm_route: assert property (
    wr_req && hit(i_cp_crn, `PAU_CRN_PERM) && i_cp_op2 == 3'h1
    |=> o_instr_perm == $past(i_cp_wdata[15:0]) &&
        $stable(o_data_perm))
    else $error("instruction permission write misrouted");
  a_read_answer: assert property (
    rd_req |=> o_cp_rvalid ##1 !o_cp_rvalid || $past(rd_req))
    else $error("read answer not a one cycle pulse");
  a_off_denied: assert property (
    !o_prot_enable |=> !o_chk_allow)
    else $error("access allowed while unit disabled");
  a_off_regions: assert property (
    !o_prot_enable |=> o_region_active == 16'h0000)
    else $error("region active while unit disabled");
  a_write_mode: assert property (
    $past(i_reset_n) |->
    o_area_write_mode[15:14] ==
      {$past(o_data_cachable[7]), $past(o_data_bufferable[7])})
    else $error("write mode not combined from attributes");
  a_reset_off: assert property (
    $rose(i_reset_n) |-> !o_prot_enable && o_region_active == 16'h0000)
    else $error("unit or regions on after reset");

  c_enable_on: cover property (wr_req && hit(i_cp_crn, `PAU_CRN_CTRL)
                               ##1 o_prot_enable);
  c_region_read: cover property (rd_req && hit(i_cp_crn, `PAU_CRN_REGION)
                                 ##1 o_cp_rvalid);
  c_allowed: cover property (o_chk_allow);
endmodule // pau_regs
`default_nettype wire

/* File: verilog/pau_defs.svh */
// Constants for the protection attribute register set
`ifndef PAU_DEFS_SVH
`define PAU_DEFS_SVH
`define PAU_CRN_CTRL    4'h1
`define PAU_CRN_CACHE   4'h2
`define PAU_CRN_BUFF    4'h3
`define PAU_CRN_RSVD    4'h4
`define PAU_CRN_PERM    4'h5
`define PAU_CRN_REGION  4'h6
`define PAU_OP2_DATA    3'h0
`define PAU_OP2_INSTR   3'h1
`define PAU_CTRL_MODE_HI 31
`define PAU_CTRL_MODE_LO 30
`define PAU_CTRL_PEN     0
`define PAU_RGN_BASE_HI  31
`define PAU_RGN_BASE_LO  12
`define PAU_RGN_SIZE_HI  5
`define PAU_RGN_SIZE_LO  1
`define PAU_RGN_EN       0
`define PAU_SIZE_MIN     5'h0B
`define PAU_AREAS        8
`define PAU_REGIONS      16
`endif

/* File: verilog/pau_pkg.sv */
// Types of the protection attribute register set
package pau_pkg;
  typedef enum logic [1:0] {
    PAU_MODE_FAST  = 2'b00,
    PAU_MODE_SYNC  = 2'b01,
    PAU_MODE_RSVD  = 2'b10,
    PAU_MODE_ASYNC = 2'b11
  } pau_clk_mode_t;

  typedef enum logic [1:0] {
    PAU_AP_NONE = 2'b00,
    PAU_AP_PRIV = 2'b01,
    PAU_AP_URD  = 2'b10,
    PAU_AP_FULL = 2'b11
  } pau_perm_t;

  typedef struct packed {
    pau_clk_mode_t mode;
    logic          prot_en;
    logic [7:0]    dcach;
    logic [7:0]    icach;
    logic [7:0]    dbuf;
    logic [15:0]   dperm;
    logic [15:0]   iperm;
    logic [31:0]   rdata;
    logic          rvalid;
    logic          allow;
    logic [15:0]   active;
    logic [15:0]   wmode;
  } pau_top_st_t;

  typedef struct packed {
    logic [15:0][19:0] base;
    logic [15:0][4:0]  size;
    logic [15:0]       en;
  } pau_rgn_st_t;
endpackage

/* File: verilog/pau_rgn_if.sv */
// Link between the register decoder and the region store
`timescale 1ns/1ns
`default_nettype none
interface pau_rgn_if;
  logic        wr;
  logic        side;
  logic [2:0]  idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [15:0] en;
  logic [15:0] sz_ok;
  modport owner (output wr, side, idx, wdata, input rdata, en, sz_ok);
  modport store (input wr, side, idx, wdata, output rdata, en, sz_ok);
endinterface
`default_nettype wire

/* File: verilog/pau_rgn_store.sv */
// Sixteen region base and size registers
`timescale 1ns/1ns
`default_nettype none
`include "pau_defs.svh"
module pau_rgn_store (
  input  wire logic  i_sys_clk,
  input  wire logic  i_reset_n,
  pau_rgn_if.store   rgn
);
  pau_pkg::pau_rgn_st_t st_ff;
  pau_pkg::pau_rgn_st_t nxt_st;
  logic [3:0]           sel;

  assign sel = {rgn.side, rgn.idx};

  always_comb
  begin
    nxt_st = st_ff;
    if (rgn.wr)
    begin
      nxt_st.base[sel] =
        rgn.wdata[`PAU_RGN_BASE_HI:`PAU_RGN_BASE_LO];
      nxt_st.size[sel] =
        rgn.wdata[`PAU_RGN_SIZE_HI:`PAU_RGN_SIZE_LO];
      nxt_st.en[sel] = rgn.wdata[`PAU_RGN_EN];
    end
    if (!i_reset_n)
      nxt_st.en = '0;
  end

  always_ff @(posedge i_sys_clk)
    st_ff <= nxt_st;

  always_comb
  begin
    rgn.rdata = {st_ff.base[sel], 6'h00, st_ff.size[sel], st_ff.en[sel]};
    rgn.en = st_ff.en;
    for (int k = 0; k < `PAU_REGIONS; k++)
      rgn.sz_ok[k] = (st_ff.size[k] >= `PAU_SIZE_MIN);
  end

  a_rgn_reset_en: assert property (@(posedge i_sys_clk)
    !i_reset_n |=> st_ff.en == 16'h0000)
    else $error("region enables not cleared by reset");
endmodule // pau_rgn_store
`default_nettype wire

/* File: bench/pau_core_model.sv */
// Core-side model issuing coprocessor register transfers
`timescale 1ns/1ns
`default_nettype none
module pau_core_model (
  input  wire logic        i_sys_clk,
  input  wire logic [31:0] i_cp_rdata,
  input  wire logic        i_cp_rvalid,
  output logic             o_cp_valid,
  output logic             o_cp_write,
  output logic [3:0]       o_cp_crn,
  output logic [3:0]       o_cp_crm,
  output logic [2:0]       o_cp_op2,
  output logic [31:0]      o_cp_wdata
);
  initial
  begin
    o_cp_valid = 1'b0;
    o_cp_write = 1'b0;
    o_cp_crn   = 4'h0;
    o_cp_crm   = 4'h0;
    o_cp_op2   = 3'h0;
    o_cp_wdata = 32'h0;
  end

  // Valid stays up so calls run back to back
  task automatic xfer(input logic wr, input logic [3:0] crn,
                      input logic [3:0] minor_coproc_reg_field, input logic [2:0] op2,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic rv);
    rd = 32'h0;
    rv = 1'b0;
    if (crn == 4'h4)
      return;
    o_cp_valid = 1'b1;
    o_cp_write = wr;
    o_cp_crn   = crn;
    o_cp_crm   = minor_coproc_reg_field;
    o_cp_op2   = op2;
    o_cp_wdata = wd;
    @(posedge i_sys_clk);
    #1;
    rd = i_cp_rdata;
    rv = i_cp_rvalid;
  endtask

  // Released data bus shows the inverse of its last value
  task automatic idle();
    o_cp_valid = 1'b0;
    o_cp_wdata = ~o_cp_wdata;
    @(posedge i_sys_clk);
    #1;
  endtask
endmodule // pau_core_model
`default_nettype wire

/* File: bench/pau_regs_bench.sv */
// Self-checking bench for the protection attribute registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module pau_regs_bench;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        valid, write, instr, user, wrt, rvalid, pen, allow;
  logic [3:0]  crn, minor_coproc_reg_field;
  logic [2:0]  op2, area;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  mode;
  logic [7:0]  dc, ic, db;
  logic [15:0] dp, ip, wm, act;
  int          err_total = 0;
  int          compares = 0;

  always #10 clk = ~clk;

  pau_regs i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cp_valid(valid),
    .i_cp_write(write), .i_cp_crn(crn), .i_cp_crm(minor_coproc_reg_field), .i_cp_op2(op2),
    .i_cp_wdata(wdata), .i_chk_instr(instr), .i_chk_area(area),
    .i_chk_user(user), .i_chk_write(wrt), .o_cp_rdata(rdata),
    .o_cp_rvalid(rvalid), .o_clock_mode(mode), .o_prot_enable(pen),
    .o_data_cachable(dc), .o_instr_cachable(ic), .o_data_bufferable(db),
    .o_data_perm(dp), .o_instr_perm(ip), .o_area_write_mode(wm),
    .o_region_active(act), .o_chk_allow(allow));

  pau_core_model i_core (.i_sys_clk(clk), .i_cp_rdata(rdata),
    .i_cp_rvalid(rvalid), .o_cp_valid(valid), .o_cp_write(write),
    .o_cp_crn(crn), .o_cp_crm(minor_coproc_reg_field), .o_cp_op2(op2), .o_cp_wdata(wdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] n, input logic [3:0] m,
                    input logic [2:0] o, input logic [31:0] d);
    logic [31:0] x;
    logic        r;
    i_core.xfer(1'b1, n, m, o, d, x, r);
  endtask

  task automatic rd(input logic [3:0] n, input logic [3:0] m,
                    input logic [2:0] o, output logic [31:0] d);
    logic r;
    i_core.xfer(1'b0, n, m, o, 32'h0, d, r);
    `CHK(r, 1'b1);
  endtask

  task automatic report_and_stop();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(20 * 3000);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    {instr, area, user, wrt} = 6'h0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(4'h6, 4'h0, 3'h0, v);
    `CHK(v[0], 1'b0);
    `CHK(act, 16'h0);
    `CHK(allow, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h1, 4'h0, 3'h0, {k[1:0], 30'h3FFFFFFE});
      rd(4'h1, 4'h0, 3'h0, v);
      `CHK(mode, k[1:0]);
      `CHK(v, {k[1:0], 30'h0});
    end
    wr(4'h2, 4'h0, 3'h0, 32'hFFFFFFA5);
    wr(4'h2, 4'h0, 3'h1, 32'h0000003C);
    wr(4'h2, 4'h0, 3'h2, 32'h00000000);
    wr(4'h3, 4'h0, 3'h0, 32'hFFFFFF0F);
    wr(4'h3, 4'h0, 3'h1, 32'h000000FF);
    rd(4'h2, 4'h0, 3'h0, v);
    `CHK(v, 32'h000000A5);
    rd(4'h2, 4'h0, 3'h1, v);
    `CHK(v, 32'h0000003C);
    rd(4'h3, 4'h0, 3'h0, v);
    `CHK(v, 32'h0000000F);
    `CHK({dc, ic}, 16'hA53C);
    `CHK(db, 8'h0F);
    for (int n = 0; n < 8; n++)
      `CHK(wm[2*n +: 2], (16'h8877 >> (2 * n)) & 16'h0003);
    wr(4'h5, 4'h0, 3'h0, 32'hABCD55E4);
    wr(4'h5, 4'h0, 3'h1, 32'h0000FF1B);
    rd(4'h5, 4'h0, 3'h0, v);
    `CHK(v, 32'h000055E4);
    `CHK({dp, ip}, 32'h55E4FF1B);
    wr(4'h6, 4'h0, 3'h0, 32'h00002FD9);
    wr(4'h6, 4'h3, 3'h1, 32'h00010017);
    wr(4'h6, 4'h5, 3'h0, 32'h00030015);
    wr(4'h6, 4'h8, 3'h0, 32'hFFFFFFFF);
    rd(4'h6, 4'h0, 3'h0, v);
    `CHK(v, 32'h00002019);
    rd(4'h6, 4'h3, 3'h1, v);
    `CHK(v, 32'h00010017);
    `CHK(act, 16'h0);
    wr(4'h1, 4'h0, 3'h0, 32'h00000001);
    i_core.idle();
    i_core.idle();
    `CHK(pen, 1'b1);
    `CHK(act, 16'h0801);
    for (int k = 0; k < 16; k++)
    begin
      area = {1'b0, k[3:2]};
      user = k[1];
      wrt = k[0];
      @(posedge clk);
      #1;
      `CHK(allow, k[3:2] == 2'h3 || (k[3:2] == 2'h1 && !k[1])
           || (k[3:2] == 2'h2 && !(k[1] && k[0])));
    end
    instr = 1'b1;
    @(posedge clk);
    #1;
    `CHK(allow, 1'b0);
    instr = 1'b0;
    wr(4'h1, 4'h0, 3'h0, 32'h00000000);
    i_core.idle();
    i_core.idle();
    `CHK(allow, 1'b0);
    `CHK(act, 16'h0);
    // Reset in mid-run keeps base and size, clears the enable
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    rd(4'h6, 4'h0, 3'h0, v);
    `CHK(v, 32'h00002018);
    `CHK(pen, 1'b0);
    report_and_stop();
  end
endmodule // pau_regs_bench
`default_nettype wire
